/* File: nfcs_pkg.sv */
// Purpose: constants for the flash command sequencer host
// Assumes: x16 parallel nor flash, command codes in hex
// Notes:   cycle counts at 200 MHz reference clock
package nfcs_pkg;
	localparam int          ADDR_W        = 27;
	localparam int          DATA_W        = 16;
	localparam logic [11:0] UNLOCK1_ADDR  = 12'h555;
	localparam logic [11:0] UNLOCK2_ADDR  = 12'h2AA;
	localparam logic [7:0]  UNLOCK1_DATA  = 8'hAA;
	localparam logic [7:0]  UNLOCK2_DATA  = 8'h55;
	localparam logic [7:0]  CMD_RESET     = 8'hF0;
	localparam logic [7:0]  CMD_AUTOSEL   = 8'h90;
	localparam logic [7:0]  CMD_BYP_ENTER = 8'h20;
	localparam logic [7:0]  CMD_BYP_EXIT2 = 8'h00;
	localparam logic [7:0]  CMD_PROGRAM   = 8'hA0;
	localparam logic [7:0]  CMD_BUF_LOAD  = 8'h25;
	localparam logic [7:0]  CMD_BUF_CONF  = 8'h29;
	localparam logic [7:0]  CMD_ERASE     = 8'h80;
	localparam logic [7:0]  CMD_DIE_ERASE = 8'h10;
	localparam logic [7:0]  CMD_BLK_ERASE = 8'h30;
	localparam int          BUF_WORDS_MAX = 512;
	localparam int          PAGE_BITS     = 9;
	// write strobe timing: setup, low, high phases in ns
	localparam int          T_SETUP_NS    = 10;
	localparam int          T_WE_LOW_NS   = 25;
	localparam int          T_WE_HIGH_NS  = 20;
	localparam int          CLK_NS        = 5;
	localparam logic [3:0]  SETUP_CYC     = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0]  LOW_CYC       = 4'((T_WE_LOW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0]  HIGH_CYC      = 4'((T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS);

	typedef enum logic [3:0] {
		NFCS_OP_RESET     = 4'h0,
		NFCS_OP_AUTOSEL   = 4'h1,
		NFCS_OP_BYP_ENTER = 4'h2,
		NFCS_OP_BYP_EXIT  = 4'h3,
		NFCS_OP_PROGRAM   = 4'h4,
		NFCS_OP_BUFFER    = 4'h5,
		NFCS_OP_DIE_ERASE = 4'h6,
		NFCS_OP_BLK_ERASE = 4'h7
	} nfcs_op_t;

	typedef enum logic [1:0] {
		NFCS_IDLE  = 2'b00,
		NFCS_SETUP = 2'b01,
		NFCS_LOW   = 2'b10,
		NFCS_HIGH  = 2'b11
	} nfcs_state_t;
endpackage

/* File: nfcs_host.sv */
// Purpose: host side sequencer issuing flash command write cycles
// Assumes: inputs synchronous to i_ref_clk; one write strobe per bus cycle
// Notes:   buffer words are streamed in by the user with a handshake
`timescale 1ns/10ps
module nfcs_host
	import nfcs_pkg::*;
#(
	parameter int BUF_MAX = nfcs_pkg::BUF_WORDS_MAX
) (
	input  wire logic                          i_ref_clk,
	input  wire logic                          i_reset_n,
	input  wire logic                          i_clk_en,
	input  wire logic                          i_cmd_valid,
	input  wire nfcs_pkg::nfcs_op_t            i_cmd_op,
	input  wire logic [nfcs_pkg::ADDR_W-1:0]   i_cmd_addr,
	input  wire logic [nfcs_pkg::DATA_W-1:0]   i_cmd_data,
	input  wire logic [9:0]                    i_cmd_count,
	input  wire logic                          i_bypass_mode,
	input  wire logic                          i_word_valid,
	input  wire logic [nfcs_pkg::PAGE_BITS-1:0] i_word_offset,
	input  wire logic [nfcs_pkg::DATA_W-1:0]   i_word_data,
	output logic                               o_cmd_ready,
	output logic                               o_word_ready,
	output logic                               o_done,
	output logic [nfcs_pkg::ADDR_W-1:0]        o_flash_addr,
	output logic [nfcs_pkg::DATA_W-1:0]        o_flash_dq,
	output logic                               o_flash_dq_oe,
	output logic                               o_flash_we_n,
	output logic                               o_flash_ce_n
);
	if (BUF_MAX < 1 || BUF_MAX > BUF_WORDS_MAX) begin : g_bad_buf_max
		$error("BUF_MAX out of range");
	end

	//--------------------------------------------------------------
	// cycle list builder
	//--------------------------------------------------------------
	nfcs_state_t              st_reg, st_next;
	nfcs_op_t                 op_reg, op_next;
	logic [3:0]               tmr_reg, tmr_next;
	logic [3:0]               step_reg, step_next;
	logic [9:0]               words_reg, words_next;
	logic [ADDR_W-1:0]        base_reg, base_next;
	logic [DATA_W-1:0]        data_reg, data_next;
	logic [9:0]               cnt_reg, cnt_next;
	logic                     byp_reg, byp_next;
	logic [ADDR_W-1:0]        addr_reg, addr_next;
	logic [DATA_W-1:0]        dq_reg, dq_next;
	logic                     oe_reg, oe_next, we_n_reg, we_n_next, ce_n_reg, ce_n_next;
	logic                     done_reg, done_next, wrdy_reg, wrdy_next, rdy_reg, rdy_next;
	logic [ADDR_W-1:0]        cyc_addr;
	logic [DATA_W-1:0]        cyc_data;
	logic                     cyc_last, cyc_word;
	logic [ADDR_W-1:0]        die_base, unl1, unl2;
	logic [3:0]               pre;

	// unlock addresses carry the die-select top bit
	assign die_base = {base_reg[ADDR_W-1:ADDR_W-1], {(ADDR_W-1){1'b0}}};
	assign unl1     = die_base | ADDR_W'(UNLOCK1_ADDR);
	assign unl2     = die_base | ADDR_W'(UNLOCK2_ADDR);

	always_comb begin
		cyc_addr = unl1;
		cyc_data = '0;
		cyc_last = 1'b0;
		cyc_word = 1'b0;
		// bypass skips the two unlock writes
		pre = (byp_reg && (op_reg == NFCS_OP_PROGRAM || op_reg == NFCS_OP_BUFFER
			|| op_reg == NFCS_OP_DIE_ERASE || op_reg == NFCS_OP_BLK_ERASE)) ? 4'h2 : 4'h0;
		if (step_reg + pre == 4'h0) begin
			cyc_data = DATA_W'(UNLOCK1_DATA);
		end else if (step_reg + pre == 4'h1) begin
			cyc_addr = unl2;
			cyc_data = DATA_W'(UNLOCK2_DATA);
		end else begin
			case (op_reg)
				// reset always issued in its three-write form
				NFCS_OP_RESET: begin
					cyc_data = DATA_W'(CMD_RESET);
					cyc_last = 1'b1;
				end
				// third write 90 at 555; reads follow
				NFCS_OP_AUTOSEL: begin
					cyc_data = DATA_W'(CMD_AUTOSEL);
					cyc_last = 1'b1;
				end
				NFCS_OP_BYP_ENTER: begin
					cyc_data = DATA_W'(CMD_BYP_ENTER);
					cyc_last = 1'b1;
				end
				// word program: A0 then data at target
				NFCS_OP_PROGRAM: begin
					if (step_reg + pre == 4'h2) begin
						cyc_data = DATA_W'(CMD_PROGRAM);
					end else begin
						cyc_addr = base_reg;
						cyc_data = data_reg;
						cyc_last = 1'b1;
					end
				end
				// buffer: 25 at block, count, words, confirm
				NFCS_OP_BUFFER: begin
					cyc_addr = base_reg;
					if (step_reg + pre == 4'h2) begin
						cyc_data = DATA_W'(CMD_BUF_LOAD);
					end else if (step_reg + pre == 4'h3) begin
						// count written is words minus one
						cyc_data = DATA_W'(cnt_reg);
					end else if (words_reg != 10'h000) begin
						// upper bits from block, low nine from word offset
						cyc_addr = {base_reg[ADDR_W-1:PAGE_BITS], i_word_offset};
						cyc_data = i_word_data;
						cyc_word = 1'b1;
					end else begin
						cyc_data = DATA_W'(CMD_BUF_CONF);
						cyc_last = 1'b1;
					end
				end
				// erase: 80, unlocks unless bypassed, then 10 or 30
				NFCS_OP_DIE_ERASE, NFCS_OP_BLK_ERASE: begin
					if (step_reg + pre == 4'h2) begin
						cyc_data = DATA_W'(CMD_ERASE);
					end else if (step_reg + pre == 4'h3 && !byp_reg) begin
						cyc_data = DATA_W'(UNLOCK1_DATA);
					end else if (step_reg + pre == 4'h4 && !byp_reg) begin
						cyc_addr = unl2;
						cyc_data = DATA_W'(UNLOCK2_DATA);
					end else begin
						cyc_last = 1'b1;
						if (op_reg == NFCS_OP_DIE_ERASE) begin
							cyc_data = DATA_W'(CMD_DIE_ERASE);
						end else begin
							cyc_addr = base_reg;
							cyc_data = DATA_W'(CMD_BLK_ERASE);
						end
					end
				end
				default: cyc_last = 1'b1;
			endcase
		end
		if (op_reg == NFCS_OP_BYP_EXIT) begin
			cyc_addr = base_reg;
			cyc_data = (step_reg == 4'h0) ? DATA_W'(CMD_AUTOSEL) : DATA_W'(CMD_BYP_EXIT2);
			cyc_last = (step_reg == 4'h1);
		end
	end

	//--------------------------------------------------------------
	// bus cycle sequencer
	//--------------------------------------------------------------
	always_comb begin
		st_next    = st_reg;
		op_next    = op_reg;
		tmr_next   = tmr_reg;
		step_next  = step_reg;
		words_next = words_reg;
		base_next  = base_reg;
		data_next  = data_reg;
		cnt_next   = cnt_reg;
		byp_next   = byp_reg;
		addr_next  = addr_reg;
		dq_next    = dq_reg;
		oe_next    = oe_reg;
		we_n_next  = we_n_reg;
		ce_n_next  = ce_n_reg;
		done_next  = 1'b0;
		wrdy_next  = 1'b0;
		case (st_reg)
			NFCS_IDLE: begin
				if (i_cmd_valid) begin
					op_next    = i_cmd_op;
					base_next  = i_cmd_addr;
					data_next  = i_cmd_data;
					cnt_next   = i_cmd_count;
					words_next = i_cmd_count + 10'h001;
					byp_next   = i_bypass_mode;
					step_next  = 4'h0;
					tmr_next   = 4'h0;
					st_next    = NFCS_SETUP;
				end
			end
			NFCS_SETUP: begin
				// word cycles wait for user data: back-pressure on the stream
				if (!cyc_word || i_word_valid) begin
					addr_next = cyc_addr;
					dq_next   = cyc_data;
					oe_next   = 1'b1;
					ce_n_next = 1'b0;
					tmr_next  = tmr_reg + 4'h1;
					if (tmr_reg + 4'h1 >= SETUP_CYC) begin
						we_n_next = 1'b0;
						tmr_next  = 4'h0;
						st_next   = NFCS_LOW;
						wrdy_next = cyc_word;
					end
				end
			end
			NFCS_LOW: begin
				tmr_next = tmr_reg + 4'h1;
				if (tmr_reg + 4'h1 >= LOW_CYC) begin
					we_n_next = 1'b1;
					tmr_next  = 4'h0;
					st_next   = NFCS_HIGH;
				end
			end
			NFCS_HIGH: begin
				tmr_next = tmr_reg + 4'h1;
				if (tmr_reg + 4'h1 >= HIGH_CYC) begin
					tmr_next  = 4'h0;
					ce_n_next = 1'b1;
					oe_next   = 1'b0;
					if (cyc_last && step_reg != 4'h0 || cyc_last && op_reg != NFCS_OP_BYP_EXIT) begin
						done_next = 1'b1;
						st_next   = NFCS_IDLE;
					end else begin
						// word counted down only once its write ends, so the confirm follows
						if (cyc_word)
							words_next = words_reg - 10'h001;
						else
							step_next = step_reg + 4'h1;
						st_next = NFCS_SETUP;
					end
				end
			end
			default: st_next = NFCS_IDLE;
		endcase
		rdy_next = (st_next == NFCS_IDLE);
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_reg    <= NFCS_IDLE;
			op_reg    <= NFCS_OP_RESET;
			tmr_reg   <= 4'h0;
			step_reg  <= 4'h0;
			words_reg <= 10'h000;
			base_reg  <= '0;
			data_reg  <= '0;
			cnt_reg   <= 10'h000;
			byp_reg   <= 1'b0;
			addr_reg  <= '0;
			dq_reg    <= '0;
			oe_reg    <= 1'b0;
			we_n_reg  <= 1'b1;
			ce_n_reg  <= 1'b1;
			done_reg  <= 1'b0;
			wrdy_reg  <= 1'b0;
			rdy_reg   <= 1'b1;
		end else if (i_clk_en) begin
			st_reg    <= st_next;
			op_reg    <= op_next;
			tmr_reg   <= tmr_next;
			step_reg  <= step_next;
			words_reg <= words_next;
			base_reg  <= base_next;
			data_reg  <= data_next;
			cnt_reg   <= cnt_next;
			byp_reg   <= byp_next;
			addr_reg  <= addr_next;
			dq_reg    <= dq_next;
			oe_reg    <= oe_next;
			we_n_reg  <= we_n_next;
			ce_n_reg  <= ce_n_next;
			done_reg  <= done_next;
			wrdy_reg  <= wrdy_next;
			rdy_reg   <= rdy_next;
		end
	end

	assign o_cmd_ready   = rdy_reg;
	assign o_word_ready  = wrdy_reg;
	assign o_done        = done_reg;
	assign o_flash_addr  = addr_reg;
	assign o_flash_dq    = dq_reg;
	assign o_flash_dq_oe = oe_reg;
	assign o_flash_we_n  = we_n_reg;
	assign o_flash_ce_n  = ce_n_reg;
endmodule // nfcs_host

/* File: nfcs_host_monitor.sv */
// Purpose: strobe and handshake checks on the sequencer host ports
// Assumes: one clock domain, async active-low reset
// Notes:   phase lengths follow the strobe figures of nfcs_pkg
`timescale 1ns/10ps
module nfcs_host_monitor
	import nfcs_pkg::*;
(
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_reset_n,
	input  wire logic                        i_clk_en,
	input  wire logic                        i_cmd_valid,
	input  wire logic                        i_word_valid,
	input  wire logic                        o_cmd_ready,
	input  wire logic                        o_word_ready,
	input  wire logic                        o_done,
	input  wire logic [nfcs_pkg::ADDR_W-1:0] o_flash_addr,
	input  wire logic [nfcs_pkg::DATA_W-1:0] o_flash_dq,
	input  wire logic                        o_flash_dq_oe,
	input  wire logic                        o_flash_we_n,
	input  wire logic                        o_flash_ce_n
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	property p_we_in_ce; !o_flash_we_n |-> !o_flash_ce_n && o_flash_dq_oe; endproperty
	a_we_in_ce: assert property (p_we_in_ce) else $error("strobe outside enable");
	property p_take; (i_clk_en && i_cmd_valid && o_cmd_ready) |=> !o_cmd_ready ##[0:1] !o_flash_ce_n;
	endproperty
	a_take: assert property (p_take) else $error("command not started");
	property p_we_low; $fell(o_flash_we_n) |-> !o_flash_we_n[*5] ##1 o_flash_we_n; endproperty
	a_we_low: assert property (p_we_low) else $error("strobe low length");
	property p_we_high; $rose(o_flash_we_n) |-> !o_flash_ce_n[*4] ##1 o_flash_ce_n; endproperty
	a_we_high: assert property (p_we_high) else $error("strobe high phase");
	property p_stable; (!o_flash_ce_n && $past(!o_flash_ce_n)) |-> $stable(o_flash_addr) && $stable(o_flash_dq);
	endproperty
	a_stable: assert property (p_stable) else $error("bus moved in cycle");
	property p_done_bound; $fell(o_cmd_ready) |-> ##[1:999] o_done; endproperty
	a_done_bound: assert property (p_done_bound) else $error("no completion");
	property p_done_pulse; o_done |-> o_flash_ce_n ##1 (!o_done && o_cmd_ready); endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("completion pulse");
	property p_word; o_word_ready |-> $past(i_word_valid) && !o_cmd_ready; endproperty
	a_word: assert property (p_word) else $error("word taken unoffered");
	property p_ready_idle; o_cmd_ready |-> o_flash_we_n && !o_word_ready; endproperty
	a_ready_idle: assert property (p_ready_idle) else $error("ready while busy");
endmodule // nfcs_host_monitor

bind nfcs_host nfcs_host_monitor i_nfcs_host_monitor (.i_ref_clk, .i_reset_n, .i_clk_en,
	.i_cmd_valid, .i_word_valid, .o_cmd_ready, .o_word_ready, .o_done, .o_flash_addr,
	.o_flash_dq, .o_flash_dq_oe, .o_flash_we_n, .o_flash_ce_n);

/* File: nfcs_flash_model.sv */
// Purpose: behavioural flash die pair logging and decoding write cycles
// Assumes: writes latched on the rising strobe while enabled
// Notes:   only unlock, bypass and auto select states decoded; operations end at once
`timescale 1ns/10ps
module nfcs_flash_model
	import nfcs_pkg::*;
(
	input  wire logic [nfcs_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [nfcs_pkg::DATA_W-1:0] i_dq,
	input  wire logic                        i_we_n,
	input  wire logic                        i_ce_n
);
	logic [ADDR_W-1:0] wr_a[$];
	logic [DATA_W-1:0] wr_d[$];
	int                step[2] = '{0, 0};
	logic              byp[2] = '{1'b0, 1'b0};
	logic              asel[2] = '{1'b0, 1'b0};
	int                d;

	always @(posedge i_we_n) if (!i_ce_n) begin
		wr_a.push_back(i_addr);
		wr_d.push_back(i_dq);
		d = int'(i_addr[ADDR_W-1]);
		// only 90 then 00 leaves bypass
		if (byp[d]) begin
			if (step[d] == 9 && i_dq == 16'h0000) byp[d] = 1'b0;
			step[d] = (i_dq == 16'h0090) ? 9 : 0;
		end else if (step[d] == 0 && i_dq == 16'h00AA && i_addr[11:0] == 12'h555)
			step[d] = 1;
		else if (step[d] == 1 && i_dq == 16'h0055 && i_addr[11:0] == 12'h2AA)
			step[d] = 2;
		else begin
			if (step[d] == 2 && i_dq == 16'h0020) byp[d] = 1'b1;
			// id reads would follow; operations end at once, so never refused
			if (step[d] == 2 && i_dq == 16'h0090) asel[d] = 1'b1;
			// nothing is ever running, so F0 returns to array read outside bypass
			if (i_dq == 16'h00F0) asel[d] = 1'b0;
			step[d] = 0;
		end
	end
endmodule // nfcs_flash_model

/* File: tb_nfcs_host.sv */
// Purpose: directed checks of the command write cycles
// Assumes: model logs every write; host compared write by write
// Notes:   buffer runs kept short so the run stays brief
`timescale 1ns/10ps
module tb_nfcs_host;
	import nfcs_pkg::*;
	logic i_ref_clk = 0, i_reset_n = 0, i_clk_en = 1, i_cmd_valid = 0;
	logic i_bypass_mode = 0, i_word_valid = 0;
	nfcs_op_t i_cmd_op = NFCS_OP_RESET;
	logic [ADDR_W-1:0] i_cmd_addr = '0, o_flash_addr;
	logic [DATA_W-1:0] i_cmd_data = '0, i_word_data = '0, o_flash_dq;
	logic [9:0] i_cmd_count = '0;
	logic [PAGE_BITS-1:0] i_word_offset = '0;
	logic o_cmd_ready, o_word_ready, o_done, o_flash_dq_oe, o_flash_we_n, o_flash_ce_n;
	int error_cnt = 0, n_compared = 0, cyc = 0, em[$];
	logic [ADDR_W-1:0] ea[$];
	logic [DATA_W-1:0] ed[$];

	nfcs_host i_nfcs_host (.i_ref_clk, .i_reset_n, .i_clk_en, .i_cmd_valid, .i_cmd_op,
		.i_cmd_addr, .i_cmd_data, .i_cmd_count, .i_bypass_mode, .i_word_valid, .i_word_offset,
		.i_word_data, .o_cmd_ready, .o_word_ready, .o_done, .o_flash_addr, .o_flash_dq,
		.o_flash_dq_oe, .o_flash_we_n, .o_flash_ce_n);
	nfcs_flash_model i_nfcs_flash_model (.i_addr(o_flash_addr), .i_dq(o_flash_dq),
		.i_we_n(o_flash_we_n), .i_ce_n(o_flash_ce_n));

	initial forever #2.5 i_ref_clk = ~i_ref_clk;
	// whole run needs well under a thousand cycles
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	// m: 0 address ignored, 1 die and low bits, 2 whole address
	task automatic e(int m, logic [ADDR_W-1:0] a, logic [15:0] d);
		em.push_back(m);
		ea.push_back(a);
		ed.push_back(d);
	endtask

	task automatic ul(logic [ADDR_W-1:0] a);
		e(1, {a[26], 26'h555}, 16'h00AA);
		e(1, {a[26], 26'h2AA}, 16'h0055);
	endtask

	task automatic run(nfcs_op_t op, logic [ADDR_W-1:0] a, logic [9:0] n, logic b, logic x);
		logic [ADDR_W-1:0] s;
		@(negedge i_ref_clk);
		i_cmd_op = op;
		i_cmd_addr = a;
		i_cmd_data = 16'h5A3C;
		i_cmd_count = n;
		i_bypass_mode = b;
		i_cmd_valid = 1;
		i_word_offset = '0;
		i_word_data = 16'hB000;
		i_word_valid = (op == NFCS_OP_BUFFER);
		@(negedge i_ref_clk);
		// a held request while busy must be ignored
		i_cmd_valid = x;
		i_cmd_op = NFCS_OP_BYP_EXIT;
		for (int k = 0; k < 3000 && o_done !== 1'b1; k++) begin
			@(negedge i_ref_clk);
			if (k == 30) i_cmd_valid = 0;
			if (o_word_ready === 1'b1) begin
				i_word_offset++;
				i_word_data++;
				i_word_valid = 32'(i_word_offset) <= 32'(n);
			end
		end
		i_cmd_valid = 0;
		chk("done", 1'b1, o_done);
		chk("write count", em.size(), i_nfcs_flash_model.wr_a.size());
		for (int k = 0; k < em.size() && k < i_nfcs_flash_model.wr_a.size(); k++) begin
			s = i_nfcs_flash_model.wr_a[k];
			if (em[k] == 1) chk("unlock addr", {ea[k][26], ea[k][11:0]}, {s[26], s[11:0]});
			if (em[k] == 2) chk("target addr", ea[k], s);
			chk("write data", ed[k], i_nfcs_flash_model.wr_d[k]);
		end
		em.delete();
		ea.delete();
		ed.delete();
		i_nfcs_flash_model.wr_a.delete();
		i_nfcs_flash_model.wr_d.delete();
	endtask

	task automatic s_reset_autosel(logic [ADDR_W-1:0] a);
		ul(a); e(0, a, 16'h00F0); run(NFCS_OP_RESET, a, 0, 0, 0);
		ul(a); e(1, {a[26], 26'h555}, 16'h0090); run(NFCS_OP_AUTOSEL, a, 0, 0, 0);
		chk("auto select", 1'b1, i_nfcs_flash_model.asel[a[26]]);
		ul(a); e(0, a, 16'h00F0); run(NFCS_OP_RESET, a, 0, 0, 0);
		chk("auto select left", 1'b0, i_nfcs_flash_model.asel[a[26]]);
	endtask

	task automatic s_bypass(logic [ADDR_W-1:0] a);
		ul(a); e(1, {a[26], 26'h555}, 16'h0020); run(NFCS_OP_BYP_ENTER, a, 0, 0, 0);
		chk("bypass die", 2'b01, {i_nfcs_flash_model.byp[1], i_nfcs_flash_model.byp[0]});
		e(0, a, 16'h00A0); e(2, a, 16'h5A3C); run(NFCS_OP_PROGRAM, a, 0, 1, 0);
		ul(a); e(0, a, 16'h00F0); run(NFCS_OP_RESET, a, 0, 1, 0);
		chk("bypass kept", 1'b1, i_nfcs_flash_model.byp[0]);
		e(0, a, 16'h0090); e(0, a, 16'h0000); run(NFCS_OP_BYP_EXIT, a, 0, 0, 0);
		chk("bypass left", 1'b0, i_nfcs_flash_model.byp[0]);
	endtask

	task automatic s_program(logic [ADDR_W-1:0] a);
		ul(a); e(1, {a[26], 26'h555}, 16'h00A0); e(2, a, 16'h5A3C);
		run(NFCS_OP_PROGRAM, a, 0, 0, 1);
	endtask

	task automatic s_buffer(logic [ADDR_W-1:0] a, logic [9:0] n, logic b);
		if (!b) ul(a);
		e(2, a, 16'h0025); e(2, a, {6'h00, n});
		for (int k = 0; k <= int'(n); k++) e(2, {a[26:9], 9'(k)}, 16'(16'hB000 + k));
		e(2, a, 16'h0029);
		run(NFCS_OP_BUFFER, a, n, b, 1);
	endtask

	task automatic s_erase(logic [ADDR_W-1:0] a);
		ul(a); e(1, {a[26], 26'h555}, 16'h0080); ul(a); e(1, {a[26], 26'h555}, 16'h0010);
		run(NFCS_OP_DIE_ERASE, a, 0, 0, 0);
		e(0, a, 16'h0080); e(0, a, 16'h0010); run(NFCS_OP_DIE_ERASE, a, 0, 1, 0);
		ul(a); e(1, {a[26], 26'h555}, 16'h0080); ul(a); e(2, a, 16'h0030);
		run(NFCS_OP_BLK_ERASE, a, 0, 0, 0);
		e(0, a, 16'h0080); e(2, a, 16'h0030); run(NFCS_OP_BLK_ERASE, a, 0, 1, 0);
	endtask

	initial begin
		repeat (16) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
		i_reset_n = 1;
		s_reset_autosel(27'h4123456);
		s_bypass(27'h0010000);
		s_program(27'h4ABCDEF);
		s_buffer(27'h43E0000, 10'h003, 0);
		s_buffer(27'h0020100, 10'h000, 1);
		s_erase(27'h4070000);
		end_of_test();
	end
endmodule // tb_nfcs_host
